// [rtl/dps_pkg.sv]
// Purpose: Shared constants and types for the digital I/O purge sequencer
// Assumes: 250 MHz system clock, AXI4-Lite register access with 32-bit data
// Notes:   Offsets are byte addresses of aligned 32-bit words
package dps_pkg;
    // Digital input and output count
    localparam int         NUM_IO        = 5;
    // Register byte offsets
    localparam logic [5:0] ADDR_CMD      = 6'h00;
    localparam logic [5:0] ADDR_CFG      = 6'h04;
    localparam logic [5:0] ADDR_PAT      = 6'h08;
    localparam logic [5:0] ADDR_TDLY     = 6'h0c;
    localparam logic [5:0] ADDR_HDLY     = 6'h10;
    localparam logic [5:0] ADDR_STAT     = 6'h14;
    // Command register bit positions (write one to act)
    localparam int         CMD_PURGE     = 0;
    localparam int         CMD_STOP      = 1;
    localparam int         CMD_SCAN_GO   = 2;
    localparam int         CMD_SCAN_END  = 3;
    localparam int         CMD_ZERO_CALIBRATION_DONE = 4;
    // Input assignment fields: 0 unassigned, 1..5 selects an input
    localparam int         SEL_W         = 3;
    localparam int         CFG_ZERO_CALIBRATION_LSB  = 0;
    localparam int         CFG_SCAN_LSB  = 4;
    localparam int         CFG_PURGE_LSB = 8;
    // Output pattern fields
    localparam int         PAT_TRANS_LSB = 0;
    localparam int         PAT_ACT_LSB   = 8;
    // Status register fields
    localparam int         STAT_MODE_LSB = 0;
    localparam int         STAT_PH_LSB   = 2;
    localparam int         STAT_RES_BIT  = 4;
    localparam int         STAT_DIN_LSB  = 8;
    localparam int         STAT_DOUT_LSB = 16;
    // Delay limits and reset values, in seconds
    localparam logic [2:0]  TDLY_RST     = 3'h1;
    localparam logic [2:0]  TDLY_MAX     = 3'h5;
    localparam logic [11:0] HDLY_RST     = 12'h00a;
    localparam logic [11:0] HDLY_MAX     = 12'he10;
    // Tick timing: one second at the system clock rate
    localparam int         CLK_HZ        = 250000000;
    localparam int         TICK_S        = 1;
    localparam int         TICK_CYCLES   = CLK_HZ * TICK_S;
    // Bus responses
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;
    // Operating modes; calibration and purge are the "other" modes
    typedef enum logic [1:0] {MODE_READY, MODE_SCAN, MODE_ZERO_CALIBRATION, MODE_PURGE} dps_mode_e;
    // Purge sequence phases
    typedef enum logic [1:0] {PH_IDLE, PH_LEAD, PH_HOLD, PH_TAIL} dps_phase_e;
endpackage

// [rtl/dps_purge_sequencer.sv]
// Purpose: Edge-triggered scan, zero calibration and timed purge sequencing
// Assumes: Inputs din are asynchronous pins; software sits on AXI4-Lite
// Notes:   All state lives in one packed struct registered once per clock
// Overview of operation
// - Five inputs, five outputs, each input assignable
// - Only rising input edges trigger a function
// - Calibration edge: start, suspending and resuming scan
// - Calibration edge ignored outside ready and scan
// - Scan edge starts when ready, stops when scanning
// - Purge command ready only; purge pin ready/scan
// - Only the selected purge input starts purge
// - Purge start drives transition pattern for delay
// - Transition delay 0..5 s, default 1, zero skips
// - Then active pattern for hold 0..3600 s
// - Stop command ends hold phase early
// - Hold zero is unlimited; stop command ends it
// - Hold end: transition pattern for another delay
// - Command purge returns to ready afterwards
// - Pin purge during scan suspends the scan
// - Pin purge returns to mode it interrupted
`timescale 1ns/100ps
module dps_purge_sequencer #(
    parameter int SEC_CYCLES = dps_pkg::TICK_CYCLES  // Clock cycles per second tick
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // AXI4-Lite write address and data
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    // AXI4-Lite write response
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    // AXI4-Lite read
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [31:0] araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    // Digital I/O pins
    input  wire logic [4:0]  din,
    output logic [4:0]       dout,
    // Mode indications
    output logic             scanActive,
    output logic             calzActive,
    output logic             purgeActive
);

    // Complete block state
    typedef struct packed {
        logic                awRdy;       // Write address ready
        logic                wRdy;        // Write data ready
        logic                arRdy;       // Read address ready
        logic                awHave;      // Write address held
        logic [5:0]          awAddr;      // Held write address
        logic                wHave;       // Write data held
        logic [31:0]         wData;       // Held write data
        logic [3:0]          wStrb;       // Held byte strobes
        logic                bValid;      // Write response pending
        logic [1:0]          bResp;       // Write response code
        logic                rValid;      // Read data pending
        logic [31:0]         rData;       // Read data
        logic [1:0]          rResp;       // Read response code
        logic [4:0]          sync1;       // First synchroniser stage
        logic [4:0]          sync2;       // Second synchroniser stage
        logic [4:0]          prevIn;      // Previous synchronised level
        logic [2:0]          calzSel;     // Calibration input assignment
        logic [2:0]          scanSel;     // Scan input assignment
        logic [2:0]          purgeSel;    // Purge input assignment
        logic [4:0]          patTrans;    // Transition output pattern
        logic [4:0]          patAct;      // Active purge output pattern
        logic [2:0]          tDly;        // Transition delay, seconds
        logic [11:0]         hDly;        // Hold delay, seconds
        dps_pkg::dps_mode_e  mode;        // Operating mode
        dps_pkg::dps_phase_e phase;       // Purge phase
        logic                resumeScan;  // Return to scan after purge or calibration
        logic                holdInf;     // Hold runs until stop
        logic [11:0]         secLeft;     // Seconds left in current phase
        logic [27:0]         tickCnt;     // Second divider
        logic [4:0]          dout;        // Output pins
        logic                scanAct;     // Scan indication
        logic                calzAct;     // Calibration indication
        logic                purgeAct;    // Purge indication
    } dps_state_s;

    dps_state_s q;  // Registered state
    dps_state_s n;  // Next state

    // Reset state: bus idle, ready mode, default delays
    function automatic dps_state_s rstState();
        dps_state_s r;
        r       = '0;
        r.awRdy = 1'b1;
        r.wRdy  = 1'b1;
        r.arRdy = 1'b1;
        r.tDly  = dps_pkg::TDLY_RST;
        r.hDly  = dps_pkg::HDLY_RST;
        r.mode  = dps_pkg::MODE_READY;
        r.phase = dps_pkg::PH_IDLE;
        return r;
    endfunction

    // Rising edge on the assigned input; zero assignment never fires
    function automatic logic selEdge(input logic [2:0] sel, input logic [4:0] rise);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < dps_pkg::NUM_IO; i++) begin
            if (sel == 3'(i + 1)) begin
                hit = rise[i];
            end
        end
        return hit;
    endfunction

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                m[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return m;
    endfunction

    // Next-state logic: bus slave, edge detection, mode and purge sequencing
    always_comb begin
        logic [4:0]  rise;
        logic        tick;
        logic        wrNow;
        logic [31:0] cmd;
        logic [31:0] cfgOld;
        logic [31:0] patOld;
        logic [31:0] val;
        logic        pinPurge;
        logic        pinCalz;
        logic        pinScan;
        logic        cmdPurge;
        logic        cmdStop;
        n        = q;
        cmd      = '0;
        cfgOld   = '0;
        patOld   = '0;
        val      = '0;
        rise     = '0;
        tick     = 1'b0;
        wrNow    = 1'b0;
        pinPurge = 1'b0;
        pinCalz  = 1'b0;
        pinScan  = 1'b0;
        cmdPurge = 1'b0;
        cmdStop  = 1'b0;
        // Input synchroniser and edge detection
        n.sync1  = din;
        n.sync2  = q.sync1;
        n.prevIn = q.sync2;
        rise     = q.sync2 & ~q.prevIn;
        pinCalz  = selEdge(q.calzSel, rise);
        pinScan  = selEdge(q.scanSel, rise);
        pinPurge = selEdge(q.purgeSel, rise);
        // One-second tick divider
        tick = (q.tickCnt == 28'(SEC_CYCLES - 1));
        n.tickCnt = tick ? 28'h0000000 : q.tickCnt + 28'h0000001;

        // Capture write address and data in either order
        if (awvalid && q.awRdy) begin
            n.awHave = 1'b1;
            n.awAddr = awaddr[5:0];
        end
        if (wvalid && q.wRdy) begin
            n.wHave = 1'b1;
            n.wData = wdata;
            n.wStrb = wstrb;
        end
        // Completed write response
        if (q.bValid && bready) begin
            n.bValid = 1'b0;
        end
        // Perform write once both halves are held
        wrNow = q.awHave && q.wHave && !q.bValid;
        if (wrNow) begin
            n.awHave = 1'b0;
            n.wHave  = 1'b0;
            n.bValid = 1'b1;
            n.bResp  = dps_pkg::RESP_OKAY;
            cfgOld   = {20'h00000, 1'b0, q.purgeSel, 1'b0, q.scanSel, 1'b0, q.calzSel};
            patOld   = {16'h0000, 3'h0, q.patAct, 3'h0, q.patTrans};
            unique case (q.awAddr)
                dps_pkg::ADDR_CMD: begin
                    cmd = mergeStrb(32'h00000000, q.wData, q.wStrb);
                end
                dps_pkg::ADDR_CFG: begin
                    val        = mergeStrb(cfgOld, q.wData, q.wStrb);
                    n.calzSel  = val[dps_pkg::CFG_ZERO_CALIBRATION_LSB +: dps_pkg::SEL_W];
                    n.scanSel  = val[dps_pkg::CFG_SCAN_LSB +: dps_pkg::SEL_W];
                    n.purgeSel = val[dps_pkg::CFG_PURGE_LSB +: dps_pkg::SEL_W];
                end
                dps_pkg::ADDR_PAT: begin
                    val        = mergeStrb(patOld, q.wData, q.wStrb);
                    n.patTrans = val[dps_pkg::PAT_TRANS_LSB +: dps_pkg::NUM_IO];
                    n.patAct   = val[dps_pkg::PAT_ACT_LSB +: dps_pkg::NUM_IO];
                end
                dps_pkg::ADDR_TDLY: begin
                    // Values above the limit clamp to it
                    val    = mergeStrb({29'h0, q.tDly}, q.wData, q.wStrb);
                    n.tDly = (val > 32'(dps_pkg::TDLY_MAX)) ? dps_pkg::TDLY_MAX : val[2:0];
                end
                dps_pkg::ADDR_HDLY: begin
                    val    = mergeStrb({20'h0, q.hDly}, q.wData, q.wStrb);
                    n.hDly = (val > 32'(dps_pkg::HDLY_MAX)) ? dps_pkg::HDLY_MAX : val[11:0];
                end
                dps_pkg::ADDR_STAT: begin
                    // Status is read-only; write accepted and dropped
                end
                default: begin
                    n.bResp = dps_pkg::RESP_SLVERR;
                end
            endcase
        end
        cmdPurge = cmd[dps_pkg::CMD_PURGE];
        cmdStop  = cmd[dps_pkg::CMD_STOP];

        // Read channel
        if (q.rValid && rready) begin
            n.rValid = 1'b0;
        end
        if (arvalid && q.arRdy) begin
            n.rValid = 1'b1;
            n.rResp  = dps_pkg::RESP_OKAY;
            n.rData  = '0;
            unique case (araddr[5:0])
                dps_pkg::ADDR_CMD: begin
                    n.rData = '0;
                end
                dps_pkg::ADDR_CFG: begin
                    n.rData[dps_pkg::CFG_ZERO_CALIBRATION_LSB +: dps_pkg::SEL_W]  = q.calzSel;
                    n.rData[dps_pkg::CFG_SCAN_LSB +: dps_pkg::SEL_W]  = q.scanSel;
                    n.rData[dps_pkg::CFG_PURGE_LSB +: dps_pkg::SEL_W] = q.purgeSel;
                end
                dps_pkg::ADDR_PAT: begin
                    n.rData[dps_pkg::PAT_TRANS_LSB +: dps_pkg::NUM_IO] = q.patTrans;
                    n.rData[dps_pkg::PAT_ACT_LSB +: dps_pkg::NUM_IO]   = q.patAct;
                end
                dps_pkg::ADDR_TDLY: begin
                    n.rData[2:0] = q.tDly;
                end
                dps_pkg::ADDR_HDLY: begin
                    n.rData[11:0] = q.hDly;
                end
                dps_pkg::ADDR_STAT: begin
                    n.rData[dps_pkg::STAT_MODE_LSB +: 2]              = q.mode;
                    n.rData[dps_pkg::STAT_PH_LSB +: 2]                = q.phase;
                    n.rData[dps_pkg::STAT_RES_BIT]                    = q.resumeScan;
                    n.rData[dps_pkg::STAT_DIN_LSB +: dps_pkg::NUM_IO]  = q.sync2;
                    n.rData[dps_pkg::STAT_DOUT_LSB +: dps_pkg::NUM_IO] = q.dout;
                end
                default: begin
                    n.rResp = dps_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Count down running purge phases on each tick
        if (q.phase != dps_pkg::PH_IDLE && tick && q.secLeft != 12'h000) begin
            n.secLeft = q.secLeft - 12'h001;
        end

        // Mode decisions on triggers
        unique case (q.mode)
            dps_pkg::MODE_READY: begin
                if (pinPurge || cmdPurge) begin
                    n.mode       = dps_pkg::MODE_PURGE;
                    n.resumeScan = 1'b0;
                    n.phase      = dps_pkg::PH_LEAD;
                    n.dout       = q.patTrans;
                    n.secLeft    = {9'h000, q.tDly};
                end else if (pinCalz) begin
                    n.mode       = dps_pkg::MODE_ZERO_CALIBRATION;
                    n.resumeScan = 1'b0;
                end else if (pinScan || cmd[dps_pkg::CMD_SCAN_GO]) begin
                    n.mode       = dps_pkg::MODE_SCAN;
                end
            end
            dps_pkg::MODE_SCAN: begin
                if (pinPurge) begin
                    n.mode       = dps_pkg::MODE_PURGE;
                    n.resumeScan = 1'b1;
                    n.phase      = dps_pkg::PH_LEAD;
                    n.dout       = q.patTrans;
                    n.secLeft    = {9'h000, q.tDly};
                end else if (pinCalz) begin
                    n.mode       = dps_pkg::MODE_ZERO_CALIBRATION;
                    n.resumeScan = 1'b1;
                end else if (pinScan || cmd[dps_pkg::CMD_SCAN_END] || cmdStop) begin
                    n.mode       = dps_pkg::MODE_READY;
                end
            end
            dps_pkg::MODE_ZERO_CALIBRATION: begin
                // Edges here are ignored; calibration ends on software report
                if (cmd[dps_pkg::CMD_ZERO_CALIBRATION_DONE]) begin
                    n.mode = q.resumeScan ? dps_pkg::MODE_SCAN : dps_pkg::MODE_READY;
                end
            end
            dps_pkg::MODE_PURGE: begin
                // New purge, scan and calibration triggers are dropped here
            end
        endcase

        // Phase advance; zero transition delays fall straight through
        if (n.phase == dps_pkg::PH_LEAD && n.secLeft == 12'h000) begin
            n.phase   = dps_pkg::PH_HOLD;
            n.dout    = q.patAct;
            n.secLeft = q.hDly;
            n.holdInf = (q.hDly == 12'h000);
        end else if (n.phase == dps_pkg::PH_HOLD &&
                     (cmdStop || (!n.holdInf && n.secLeft == 12'h000))) begin
            n.phase   = dps_pkg::PH_TAIL;
            n.dout    = q.patTrans;
            n.secLeft = {9'h000, q.tDly};
        end
        if (n.phase == dps_pkg::PH_TAIL && n.secLeft == 12'h000) begin
            n.phase   = dps_pkg::PH_IDLE;
            n.dout    = '0;
            n.holdInf = 1'b0;
            n.mode    = n.resumeScan ? dps_pkg::MODE_SCAN : dps_pkg::MODE_READY;
        end
        // Phase changes restart the second divider for whole-second timing
        if (n.phase != q.phase) begin
            n.tickCnt = 28'h0000000;
        end

        // Registered handshake readies and indications
        n.awRdy    = !n.awHave && !n.bValid;
        n.wRdy     = !n.wHave && !n.bValid;
        n.arRdy    = !n.rValid;
        n.scanAct  = (n.mode == dps_pkg::MODE_SCAN);
        n.calzAct  = (n.mode == dps_pkg::MODE_ZERO_CALIBRATION);
        n.purgeAct = (n.mode == dps_pkg::MODE_PURGE);
    end

    // State register with synchronous reset
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            q <= rstState();
        end else begin
            q <= n;
        end
    end

    // Outputs straight from state flops
    assign awready     = q.awRdy;
    assign wready      = q.wRdy;
    assign bvalid      = q.bValid;
    assign bresp       = q.bResp;
    assign arready     = q.arRdy;
    assign rvalid      = q.rValid;
    assign rdata       = q.rData;
    assign rresp       = q.rResp;
    assign dout        = q.dout;
    assign scanActive  = q.scanAct;
    assign calzActive  = q.calzAct;
    assign purgeActive = q.purgeAct;

endmodule

// [tb/dps_io_partner.sv]
// Purpose: External equipment that pulses the digital inputs
// Assumes: Pins are active high and rest low when not driven
// Notes:   Each pulse rises cleanly, holds a few cycles, then falls
`timescale 1ns/100ps
module dps_io_partner (
    // Clock
    input  logic       mclk,
    // Pulse request: input number 1..5
    input  logic       fire,
    input  logic [2:0] pinSel,
    // Driven pins
    output logic [4:0] din
);
    logic [2:0] holdCnt;  // Cycles left in the current pulse
    initial din = 5'h00;
    initial holdCnt = 3'h0;
    // Raise one pin low-to-high, then release it after four cycles
    always @(posedge mclk) begin
        if (fire) begin
            din <= din | (5'h01 << (pinSel - 3'h1));
            holdCnt <= 3'h4;
        end else if (holdCnt != 3'h0) begin
            holdCnt <= holdCnt - 3'h1;
            if (holdCnt == 3'h1) din <= 5'h00;
        end
    end
endmodule

// [tb/dps_purge_sequencer_checker.sv]
// Purpose: Concurrent checks on the purge sequencer's ports
// Assumes: Single clock domain, synchronous active-low reset
// Notes:   Bound to every instance of the sequencer
`timescale 1ns/100ps
module dps_purge_sequencer_checker #(
    parameter int SEC_CYCLES = 20  // Cycles per second tick
) (
    // Clock and reset
    input logic        mclk,
    input logic        nrst,
    // Bus handshakes
    input logic        awready,
    input logic        wready,
    input logic        bvalid,
    input logic        bready,
    input logic [1:0]  bresp,
    input logic        arvalid,
    input logic        arready,
    input logic        rvalid,
    input logic        rready,
    input logic [31:0] rdata,
    // Pins and mode flags
    input logic [4:0]  dout,
    input logic        scanActive,
    input logic        calzActive,
    input logic        purgeActive
);
    // All checks share the system clock and its reset
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // Outputs rest low whenever no purge runs
    a_dout_idle: assert property (!purgeActive |-> dout == 5'h00)
        else $error("dout driven outside a purge");
    // Only one mode flag may be up
    a_mode_single: assert property ($onehot0({scanActive, calzActive, purgeActive}))
        else $error("more than one mode flag high");
    // Calibration never starts out of a purge
    a_zero_calibration_blocked: assert property ($rose(calzActive) |-> !$past(purgeActive))
        else $error("calibration began during purge");
    // Purge never starts out of a calibration
    a_purge_blocked: assert property ($rose(purgeActive) |-> !$past(calzActive))
        else $error("purge began during calibration");
    // Write response holds until accepted
    a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    // Read data holds until accepted
    a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    // A pending read blocks the next address
    a_ar_block: assert property (rvalid |-> !arready)
        else $error("read address open while data pending");
    // A pending response blocks new writes
    a_aw_block: assert property (bvalid |-> !awready && !wready)
        else $error("write channels open while response pending");
    // A taken read is answered one edge later
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read not answered in one cycle");
endmodule
bind dps_purge_sequencer dps_purge_sequencer_checker #(.SEC_CYCLES(SEC_CYCLES)) i_dps_purge_sequencer_checker (
    .mclk(mclk), .nrst(nrst), .awready(awready), .wready(wready), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .dout(dout), .scanActive(scanActive), .calzActive(calzActive), .purgeActive(purgeActive));

// [tb/test_dps_purge_sequencer.sv]
// Purpose: Directed bus and pin tests of the purge sequencer
// Assumes: Shortened second of 20 cycles
// Notes:   Phase checks sample three cycles into each phase to absorb divider slack
`timescale 1ns/100ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module test_dps_purge_sequencer;
    localparam int SEC = 20;  // Cycles per simulated second
    logic        mclk, nrst, awvalid, wvalid, bready, arvalid, rready, fire;
    logic [31:0] awaddr, wdata, araddr, rdata, rv;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs;
    logic [2:0]  pinSel;
    logic [4:0]  din, dout;
    logic        awready, wready, bvalid, arready, rvalid, scanActive, calzActive, purgeActive;
    int          error_cnt, check_count;
    // Device and external equipment
    dps_purge_sequencer #(.SEC_CYCLES(SEC)) i_dps_purge_sequencer (.mclk, .nrst, .awvalid, .awready, .awaddr,
        .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
        .rready, .rdata, .rresp, .din, .dout, .scanActive, .calzActive, .purgeActive);
    dps_io_partner i_dps_io_partner (.mclk, .fire, .pinSel, .din);
    // Clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // Verdict and end of run
    task end_of_test();
        if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Register write; the response must be OKAY
    task wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge mclk);
        awaddr <= {26'h0, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(negedge mclk); while (!(awready && wready));
        @(posedge mclk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(negedge mclk); while (!bvalid);
        `CHK("bresp", dps_pkg::RESP_OKAY, bresp)
        @(posedge mclk);
        bready <= 1'b0;
    endtask
    // Register read into rv and rs
    task rd(input logic [5:0] a);
        @(posedge mclk);
        araddr <= {26'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge mclk); while (!arready);
        @(posedge mclk);
        arvalid <= 1'b0;
        do @(negedge mclk); while (!rvalid);
        rv = rdata;
        rs = rresp;
        @(posedge mclk);
        rready <= 1'b0;
    endtask
    // Ask the partner for one pin pulse
    task pin(input logic [2:0] p);
        @(posedge mclk);
        pinSel <= p;
        fire <= 1'b1;
        @(posedge mclk);
        fire <= 1'b0;
    endtask
    // Let n edges pass, then settle at the falling edge
    task cyc(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask
    // Watchdog
    initial begin
        repeat (5000) @(posedge mclk);
        error_cnt++;
        end_of_test();
    end
    // Main sequence
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, fire, nrst} = '0;
        {awaddr, wdata, araddr, pinSel} = '0;
        wstrb = 4'hf;
        error_cnt = 0;
        check_count = 0;
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        rd(dps_pkg::ADDR_TDLY);
        `CHK("tdly reset", dps_pkg::TDLY_RST, rv[2:0])
        rd(dps_pkg::ADDR_HDLY);
        `CHK("hdly reset", dps_pkg::HDLY_RST, rv[11:0])
        rd(6'h18);
        `CHK("unmapped", dps_pkg::RESP_SLVERR, rs)
        wr(dps_pkg::ADDR_TDLY, 32'h7);
        rd(dps_pkg::ADDR_TDLY);
        `CHK("tdly clamp", dps_pkg::TDLY_MAX, rv[2:0])
        // Unassigned input does nothing
        pin(3'h2);
        cyc(8);
        `CHK("scan unassigned", 1'b0, scanActive)
        wr(dps_pkg::ADDR_CFG, 32'h321);
        wr(dps_pkg::ADDR_PAT, 32'h150a);
        wr(dps_pkg::ADDR_TDLY, 32'h1);
        wr(dps_pkg::ADDR_HDLY, 32'h2);
        pin(3'h2);
        cyc(8);
        `CHK("scan start", 1'b1, scanActive)
        `CHK("no purge", 1'b0, purgeActive)
        cyc(8);
        `CHK("falling edge", 1'b1, scanActive)
        wr(dps_pkg::ADDR_CMD, 32'h1);
        cyc(2);
        `CHK("cmd purge in scan", 1'b0, purgeActive)
        pin(3'h1);
        cyc(8);
        `CHK("zero_calibration start", 1'b1, calzActive)
        pin(3'h2);
        cyc(8);
        `CHK("scan pin in zero_calibration", 1'b1, calzActive)
        wr(dps_pkg::ADDR_CMD, 32'h10);
        cyc(2);
        `CHK("scan resume", 1'b1, scanActive)
        // Pin purge out of scan: lead, hold, tail, resume
        pin(3'h3);
        cyc(6);
        `CHK("purge pin", 1'b1, purgeActive)
        `CHK("lead pattern", 5'h0a, dout)
        pin(3'h1);
        cyc(18);
        `CHK("hold pattern", 5'h15, dout)
        `CHK("zero_calibration in purge", 1'b0, calzActive)
        pin(3'h3);
        cyc(38);
        `CHK("tail pattern", 5'h0a, dout)
        cyc(20);
        `CHK("scan back", 1'b1, scanActive)
        `CHK("dout released", 5'h00, dout)
        pin(3'h2);
        cyc(8);
        `CHK("scan stop", 1'b0, scanActive)
        // Software scan start and scan end commands
        wr(dps_pkg::ADDR_CMD, 32'h4);
        cyc(2);
        `CHK("cmd scan go", 1'b1, scanActive)
        wr(dps_pkg::ADDR_CMD, 32'h8);
        cyc(2);
        `CHK("cmd scan end", 1'b0, scanActive)
        // Command purge, no transition, unlimited hold
        wr(dps_pkg::ADDR_TDLY, 32'h0);
        wr(dps_pkg::ADDR_HDLY, 32'h0);
        wr(dps_pkg::ADDR_CMD, 32'h1);
        cyc(2);
        `CHK("skip lead", 5'h15, dout)
        cyc(100);
        `CHK("unlimited hold", 5'h15, dout)
        // Status shows purge mode, hold phase, no resume, active pattern
        rd(dps_pkg::ADDR_STAT);
        `CHK("status hold", 5'h0b, rv[4:0])
        `CHK("status dout", 5'h15, rv[20:16])
        wr(dps_pkg::ADDR_CMD, 32'h2);
        cyc(2);
        `CHK("stop ends purge", 1'b0, purgeActive)
        `CHK("ready outputs", 5'h00, dout)
        // Pin purge from ready returns to ready after stop
        pin(3'h3);
        cyc(6);
        `CHK("pin purge ready", 1'b1, purgeActive)
        wr(dps_pkg::ADDR_CMD, 32'h2);
        cyc(2);
        `CHK("back to ready", 1'b0, purgeActive | scanActive)
        end_of_test();
    end
endmodule
